// ===== design/mslog_params.svh
// Register map, field positions, reset values and timing constants of the meter state and event logger.
`ifndef MSLOG_PARAMS_SVH
`define MSLOG_PARAMS_SVH

// ==========================================================================
// Register byte offsets
`define MSLOG_ADR_CTRL 8'h00
`define MSLOG_ADR_CMD 8'h04
`define MSLOG_ADR_STATUS 8'h08
`define MSLOG_ADR_INFO_MASK 8'h0c
`define MSLOG_ADR_MEAS_SEQ 8'h10
`define MSLOG_ADR_CONFIG_NUM 8'h14
`define MSLOG_ADR_EVENT_COUNT 8'h18
`define MSLOG_ADR_LOG_SEL 8'h1c
`define MSLOG_ADR_LOG_DATA 8'h20
`define MSLOG_ADR_PEAK_TIME 8'h24
`define MSLOG_ADR_PEAK_DATE 8'h28

// ==========================================================================
// Field positions
`define MSLOG_CTRL_SUMMER_EN 0
`define MSLOG_CTRL_READ_INCL 1
`define MSLOG_CTRL_SETUP_ALLOW 2
`define MSLOG_CTRL_TEST_MENU 3
`define MSLOG_CMD_ENTER_SETUP 0
`define MSLOG_CMD_LEAVE_SETUP 1
`define MSLOG_CMD_FINISH 2
`define MSLOG_CMD_RADIO_ON 3
`define MSLOG_SEL_LOG 0
`define MSLOG_SEL_IDX_LSB 8
`define MSLOG_SEL_WORD_LSB 16
`define MSLOG_OFFSET_BIT 16

// ==========================================================================
// Reset values
`define MSLOG_CTRL_RESET 4'h4
`define MSLOG_INFO_MASK_RESET 12'hfff
`define MSLOG_MEAS_SEQ_RESET 4'h0
`define MSLOG_REDUCED_SEQ 4'hf

// ==========================================================================
// Log sizes and time of day
`define MSLOG_INFO_DEPTH 50
`define MSLOG_CFG_DEPTH 25
`define MSLOG_INFO_WIDTH 142
`define MSLOG_CFG_WIDTH 210
`define MSLOG_SEC_PER_DAY 17'h15180
`define MSLOG_SUMMER_SEC 17'h00e10

`endif

// ===== design/mslog_pkg.sv
// Types shared by the meter state and event logger.
package mslog_pkg;

	// ==========================================================================
	// Meter life cycle
	typedef enum logic {
		MSLOG_TRANSPORT,
		MSLOG_OPERATIONAL
	} mslog_state_type;

endpackage : mslog_pkg

// ===== design/mslog_log_mem.sv
// Log entry store: one write port, asynchronous read port.
module mslog_log_mem #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4,
	parameter int AW = 2
) (
	// Clock
	input wire logic clk,
	// Write side
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data,
	// Read side
	input wire logic [AW-1:0] rd_addr,
	output logic [WIDTH-1:0] rd_data
);

	// No reset on the array: entries beyond the fill count are never returned.
	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	assign rd_data = mem[rd_addr];

endmodule : mslog_log_mem

// ===== design/mslog_top.sv
// Meter transport state, radio gating, information and configuration logs, summer time rendering.
//
// Behaviour
// (R1) Power up in transport until first integration.
// (R2) Transport: no info logging, no event counting.
// (R3) Transport: use reduced-power measuring sequence.
// (R4) Transport: setup allowed if country code permits.
// (R5) Finish configuration blocks setup, leaves transport.
// (R6) After transport: log codes, ordered sequence.
// (R7) Transport only re-entered by total reset.
// (R8) Radio off on delivery, on at integration.
// (R9) Setup may enable radio without leaving transport.
// (R10) Test menu: radio off, never turned on.
// (R11) Info entry: date, time, code, energies, volume.
// (R12) Keep latest 50 info changes, all readable.
// (R13) Only country-enabled code bits raise events.
// (R14) Event bumps counter and logs, except transport.
// (R15) Mask changes never alter stored entries.
// (R16) Config entry: date, time, number, counters, offset.
// (R17) At most 25 config changes until reset.
// (R18) Every setup visit writes a config entry.
// (R19) Store standard time plus offset; render per enable.
// (R20) Scheduled logging at standard-time midnight.
// (R21) Peak stamps stored standard, shown with offset.
// (R22) Readout: separate offset or offset included.
// (R23) Full info log overwrites its oldest entry.
//
// Decided for this implementation: register access over Wishbone and the register offsets.
`include "mslog_params.svh"

module mslog_top (
	// Clock and reset
	input wire logic MCLK,
	input wire logic RESETN,
	// Wishbone slave
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [7:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	// Metering events
	input wire logic INTEGRATION,
	input wire logic FORCED_CALL,
	input wire logic PEAK_STROBE,
	input wire logic [11:0] INFO_CODE,
	// Counters captured into log entries
	input wire logic [31:0] HEAT_ENERGY,
	input wire logic [31:0] COOLING_ENERGY,
	input wire logic [31:0] VOLUME_TOTAL,
	input wire logic [31:0] HOUR_COUNTER,
	input wire logic [15:0] TEMP_OFFSET,
	// Standard time from the meter clock
	input wire logic [15:0] TIME_DATE,
	input wire logic [16:0] TIME_SEC,
	input wire logic SUMMER_PERIOD,
	// Meter control
	output logic TRANSPORT_STATE,
	output logic RADIO_EN,
	output logic SETUP_ACTIVE,
	output logic [3:0] MEAS_SEQ_SEL,
	output logic SCHED_LOG
);

	// ==========================================================================
	// Helpers
	function automatic logic [31:0] merge_lanes(input logic [31:0] old_v, input logic [31:0] new_v,
			input logic [3:0] sel);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge_lanes

	// Newest entry is index zero; the pointer marks the next slot to fill.
	function automatic logic [5:0] ring_index(input logic [5:0] ptr, input logic [5:0] idx,
			input logic [5:0] depth);
		logic [6:0] s;
		s = {1'b0, ptr} + {1'b0, depth} - 7'h01 - {1'b0, idx};
		if (s >= {1'b0, depth}) begin
			s = s - {1'b0, depth};
		end
		return s[5:0];
	endfunction : ring_index

	// Renders a stored standard time. The offset either lands in bit 17 of the word or is added in.
	// The date is not rolled when the added hour crosses midnight; readout software must allow for that.
	function automatic logic [31:0] render_time(input logic [16:0] sec, input logic off, input logic en,
			input logic incl);
		logic [17:0] t;
		logic [31:0] r;
		t = {1'b0, sec};
		r = 32'h0;
		if (off && en && incl) begin
			t = t + {1'b0, `MSLOG_SUMMER_SEC};
			if (t >= {1'b0, `MSLOG_SEC_PER_DAY}) begin
				t = t - {1'b0, `MSLOG_SEC_PER_DAY};
			end
		end
		r[16:0] = t[16:0];
		r[`MSLOG_OFFSET_BIT + 1] = off && en && !incl;
		return r;
	endfunction : render_time

	// ==========================================================================
	// State
	mslog_pkg::mslog_state_type state_reg, state_next;
	logic radio_reg, radio_next;
	logic setup_active_reg, setup_active_next;
	logic setup_blocked_reg, setup_blocked_next;
	logic [3:0] ctrl_reg;
	logic [11:0] info_mask_reg;
	logic [3:0] meas_seq_reg;
	logic [31:0] config_num_reg;
	logic [31:0] event_count_reg;
	logic [18:0] log_sel_reg;
	logic [11:0] code_prev_reg;
	logic [5:0] info_ptr_reg;
	logic [5:0] info_fill_reg;
	logic [5:0] cfg_count_reg;
	logic [16:0] peak_sec_reg;
	logic [15:0] peak_date_reg;
	logic [16:0] sec_prev_reg;
	logic sched_reg;
	logic ack_reg;
	logic [31:0] rdata_reg;
	logic transport_out_reg;

	// ==========================================================================
	// Bus decode
	wire bus_req = WB_CYC_I && WB_STB_I && !ack_reg;
	wire bus_wr = bus_req && WB_WE_I;
	wire hit_ctrl = WB_ADR_I == `MSLOG_ADR_CTRL;
	wire hit_cmd = WB_ADR_I == `MSLOG_ADR_CMD;
	wire hit_mask = WB_ADR_I == `MSLOG_ADR_INFO_MASK;
	wire hit_seq = WB_ADR_I == `MSLOG_ADR_MEAS_SEQ;
	wire hit_cfgnum = WB_ADR_I == `MSLOG_ADR_CONFIG_NUM;
	wire hit_sel = WB_ADR_I == `MSLOG_ADR_LOG_SEL;
	wire [31:0] cmd_word = merge_lanes(32'h0, WB_DAT_I, WB_SEL_I);
	wire cmd_wr = bus_wr && hit_cmd;
	wire cmd_enter = cmd_wr && cmd_word[`MSLOG_CMD_ENTER_SETUP];
	wire cmd_leave = cmd_wr && cmd_word[`MSLOG_CMD_LEAVE_SETUP];
	wire cmd_finish = cmd_wr && cmd_word[`MSLOG_CMD_FINISH];
	wire cmd_radio = cmd_wr && cmd_word[`MSLOG_CMD_RADIO_ON];
	wire [31:0] ctrl_merged = merge_lanes({28'h0, ctrl_reg}, WB_DAT_I, WB_SEL_I);
	wire [31:0] mask_merged = merge_lanes({20'h0, info_mask_reg}, WB_DAT_I, WB_SEL_I);
	wire [31:0] seq_merged = merge_lanes({28'h0, meas_seq_reg}, WB_DAT_I, WB_SEL_I);
	wire [31:0] sel_merged = merge_lanes({13'h0, log_sel_reg}, WB_DAT_I, WB_SEL_I);

	// ==========================================================================
	// Control decode
	wire summer_en = ctrl_reg[`MSLOG_CTRL_SUMMER_EN];
	wire read_incl = ctrl_reg[`MSLOG_CTRL_READ_INCL];
	wire setup_allow = ctrl_reg[`MSLOG_CTRL_SETUP_ALLOW];
	wire test_menu = ctrl_reg[`MSLOG_CTRL_TEST_MENU];
	wire in_transport = state_reg == mslog_pkg::MSLOG_TRANSPORT;
	wire cfg_room = cfg_count_reg < 6'(`MSLOG_CFG_DEPTH);
	wire setup_open = !setup_blocked_reg && setup_allow && cfg_room && !test_menu; // R4 R17
	wire setup_close = setup_active_reg && (cmd_leave || cmd_finish);

	// ==========================================================================
	// Transport state, setup access and radio
	always_comb begin
		state_next = state_reg;
		setup_active_next = setup_active_reg;
		setup_blocked_next = setup_blocked_reg;
		radio_next = radio_reg;
		case (state_reg)
			mslog_pkg::MSLOG_TRANSPORT: begin
				if (INTEGRATION || (setup_active_reg && cmd_finish)) begin
					state_next = mslog_pkg::MSLOG_OPERATIONAL; // R1 R5
				end
			end
			mslog_pkg::MSLOG_OPERATIONAL: begin
				state_next = mslog_pkg::MSLOG_OPERATIONAL; // R7
			end
			default: begin
				state_next = mslog_pkg::MSLOG_TRANSPORT;
			end
		endcase
		if (cmd_enter && setup_open) begin
			setup_active_next = 1'b1;
		end
		if (setup_close) begin
			setup_active_next = 1'b0;
		end
		if (setup_active_reg && cmd_finish) begin
			setup_blocked_next = 1'b1; // R5
		end
		if (test_menu) begin
			radio_next = 1'b0; // R10
		end else if (INTEGRATION || FORCED_CALL) begin
			radio_next = 1'b1; // R8
		end else if (setup_active_reg && cmd_radio) begin
			radio_next = 1'b1; // R9
		end
	end

	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			state_reg <= mslog_pkg::MSLOG_TRANSPORT; // R1
			setup_active_reg <= 1'b0;
			setup_blocked_reg <= 1'b0;
			radio_reg <= 1'b0; // R8
		end else begin
			state_reg <= state_next;
			setup_active_reg <= setup_active_next;
			setup_blocked_reg <= setup_blocked_next;
			radio_reg <= radio_next;
		end
	end

	// ==========================================================================
	// Software registers
	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			ctrl_reg <= `MSLOG_CTRL_RESET;
			info_mask_reg <= `MSLOG_INFO_MASK_RESET;
			meas_seq_reg <= `MSLOG_MEAS_SEQ_RESET;
			config_num_reg <= 32'h0;
			log_sel_reg <= 19'h0;
		end else begin
			if (bus_wr && hit_ctrl) begin
				ctrl_reg <= ctrl_merged[3:0];
			end
			if (bus_wr && hit_mask) begin
				info_mask_reg <= mask_merged[11:0]; // R15
			end
			if (bus_wr && hit_seq) begin
				meas_seq_reg <= seq_merged[3:0];
			end
			if (bus_wr && hit_cfgnum) begin
				config_num_reg <= merge_lanes(config_num_reg, WB_DAT_I, WB_SEL_I);
			end
			if (bus_wr && hit_sel) begin
				log_sel_reg <= sel_merged[18:0];
			end
		end
	end

	// ==========================================================================
	// Information events and log
	wire [11:0] code_masked = INFO_CODE & info_mask_reg; // R13
	wire info_event = (code_masked != (code_prev_reg & info_mask_reg)) && !in_transport; // R2 R14
	wire info_full = info_fill_reg == 6'(`MSLOG_INFO_DEPTH);
	wire info_wrap = info_ptr_reg == 6'(`MSLOG_INFO_DEPTH - 1);
	wire [`MSLOG_INFO_WIDTH-1:0] info_entry = {VOLUME_TOTAL, COOLING_ENERGY, HEAT_ENERGY, code_masked,
		SUMMER_PERIOD, TIME_DATE, TIME_SEC}; // R11 R19

	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			code_prev_reg <= 12'h0;
			event_count_reg <= 32'h0;
			info_ptr_reg <= 6'h0;
			info_fill_reg <= 6'h0;
		end else begin
			code_prev_reg <= INFO_CODE;
			if (info_event) begin
				event_count_reg <= event_count_reg + 32'h1; // R14
				info_ptr_reg <= info_wrap ? 6'h0 : info_ptr_reg + 6'h1; // R23
				if (!info_full) begin
					info_fill_reg <= info_fill_reg + 6'h1; // R12
				end
			end
		end
	end

	// ==========================================================================
	// Configuration log
	wire cfg_write = setup_close && cfg_room; // R18
	wire [`MSLOG_CFG_WIDTH-1:0] cfg_entry = {TEMP_OFFSET, HOUR_COUNTER, VOLUME_TOTAL, COOLING_ENERGY,
		HEAT_ENERGY, config_num_reg, SUMMER_PERIOD, TIME_DATE, TIME_SEC}; // R16

	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			cfg_count_reg <= 6'h0; // R17
		end else if (cfg_write) begin
			cfg_count_reg <= cfg_count_reg + 6'h1; // R17
		end
	end

	// ==========================================================================
	// Log readout
	wire sel_cfg = log_sel_reg[`MSLOG_SEL_LOG];
	wire [5:0] sel_idx = log_sel_reg[`MSLOG_SEL_IDX_LSB +: 6];
	wire [2:0] sel_word = log_sel_reg[`MSLOG_SEL_WORD_LSB +: 3];
	wire [5:0] info_rd_addr = ring_index(info_ptr_reg, sel_idx, 6'(`MSLOG_INFO_DEPTH)); // R12
	wire [5:0] cfg_rd_addr = ring_index(cfg_count_reg, sel_idx, 6'(`MSLOG_CFG_DEPTH));
	wire [`MSLOG_INFO_WIDTH-1:0] info_rd;
	wire [`MSLOG_CFG_WIDTH-1:0] cfg_rd;

	mslog_log_mem #(
		.WIDTH(`MSLOG_INFO_WIDTH),
		.DEPTH(`MSLOG_INFO_DEPTH),
		.AW(6)
	) u_info_mem (
		.clk(MCLK),
		.wr_en(info_event),
		.wr_addr(info_ptr_reg),
		.wr_data(info_entry),
		.rd_addr(info_rd_addr),
		.rd_data(info_rd)
	);

	mslog_log_mem #(
		.WIDTH(`MSLOG_CFG_WIDTH),
		.DEPTH(`MSLOG_CFG_DEPTH),
		.AW(5)
	) u_cfg_mem (
		.clk(MCLK),
		.wr_en(cfg_write),
		.wr_addr(cfg_count_reg[4:0]),
		.wr_data(cfg_entry),
		.rd_addr(cfg_rd_addr[4:0]),
		.rd_data(cfg_rd)
	);

	// Both entries share their low 34 bits: time, date and the offset in force when logged.
	wire [16:0] ent_sec = sel_cfg ? cfg_rd[16:0] : info_rd[16:0];
	wire [15:0] ent_date = sel_cfg ? cfg_rd[32:17] : info_rd[32:17];
	wire ent_off = sel_cfg ? cfg_rd[33] : info_rd[33];
	wire [31:0] ent_time = render_time(ent_sec, ent_off, summer_en, read_incl); // R19 R22
	wire ent_valid = sel_cfg ? (sel_idx < cfg_count_reg) : (sel_idx < info_fill_reg);
	logic [31:0] info_word;
	logic [31:0] cfg_word;

	always_comb begin
		case (sel_word)
			3'h0: info_word = ent_time;
			3'h1: info_word = {16'h0, ent_date};
			3'h2: info_word = {20'h0, info_rd[45:34]};
			3'h3: info_word = info_rd[77:46];
			3'h4: info_word = info_rd[109:78];
			3'h5: info_word = info_rd[141:110];
			default: info_word = 32'h0;
		endcase
		case (sel_word)
			3'h0: cfg_word = ent_time;
			3'h1: cfg_word = {16'h0, ent_date};
			3'h2: cfg_word = cfg_rd[65:34];
			3'h3: cfg_word = cfg_rd[97:66];
			3'h4: cfg_word = cfg_rd[129:98];
			3'h5: cfg_word = cfg_rd[161:130];
			3'h6: cfg_word = cfg_rd[193:162];
			default: cfg_word = {16'h0, cfg_rd[209:194]};
		endcase
	end

	wire [31:0] log_word = !ent_valid ? 32'h0 : (sel_cfg ? cfg_word : info_word);

	// ==========================================================================
	// Peak stamps and scheduled logging
	wire [31:0] peak_time = render_time(peak_sec_reg, SUMMER_PERIOD, summer_en, read_incl); // R21

	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			peak_sec_reg <= 17'h0;
			peak_date_reg <= 16'h0;
			sec_prev_reg <= 17'h0;
			sched_reg <= 1'b0;
		end else begin
			if (PEAK_STROBE) begin
				peak_sec_reg <= TIME_SEC; // R21
				peak_date_reg <= TIME_DATE;
			end
			sec_prev_reg <= TIME_SEC;
			// Standard midnight is 00.00 local in winter and 01.00 local in summer, so one compare serves.
			sched_reg <= (TIME_SEC == 17'h0) && (sec_prev_reg != 17'h0); // R20
		end
	end

	// ==========================================================================
	// Read mux and acknowledge
	wire [31:0] status_word = {10'h0, info_fill_reg, 2'h0, cfg_count_reg, 3'h0, test_menu,
		setup_blocked_reg, setup_active_reg, radio_reg, in_transport};
	logic [31:0] rd_mux;

	always_comb begin
		case (WB_ADR_I)
			`MSLOG_ADR_CTRL: rd_mux = {28'h0, ctrl_reg};
			`MSLOG_ADR_STATUS: rd_mux = status_word;
			`MSLOG_ADR_INFO_MASK: rd_mux = {20'h0, info_mask_reg};
			`MSLOG_ADR_MEAS_SEQ: rd_mux = {28'h0, meas_seq_reg};
			`MSLOG_ADR_CONFIG_NUM: rd_mux = config_num_reg;
			`MSLOG_ADR_EVENT_COUNT: rd_mux = event_count_reg;
			`MSLOG_ADR_LOG_SEL: rd_mux = {13'h0, log_sel_reg};
			`MSLOG_ADR_LOG_DATA: rd_mux = log_word;
			`MSLOG_ADR_PEAK_TIME: rd_mux = peak_time;
			`MSLOG_ADR_PEAK_DATE: rd_mux = {16'h0, peak_date_reg};
			default: rd_mux = 32'h0;
		endcase
	end

	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			ack_reg <= 1'b0;
			rdata_reg <= 32'h0;
		end else begin
			ack_reg <= bus_req;
			rdata_reg <= (bus_req && !WB_WE_I) ? rd_mux : 32'h0;
		end
	end

	// ==========================================================================
	// Outputs
	assign WB_ACK_O = ack_reg;
	assign WB_DAT_O = rdata_reg;
	assign TRANSPORT_STATE = transport_out_reg;
	assign RADIO_EN = radio_reg;
	assign SETUP_ACTIVE = setup_active_reg;
	assign SCHED_LOG = sched_reg;

	logic [3:0] seq_out_reg;

	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			seq_out_reg <= `MSLOG_REDUCED_SEQ;
			transport_out_reg <= 1'b1; // R1
		end else begin
			seq_out_reg <= (state_next == mslog_pkg::MSLOG_TRANSPORT) ? `MSLOG_REDUCED_SEQ : meas_seq_reg; // R3 R6
			transport_out_reg <= state_next == mslog_pkg::MSLOG_TRANSPORT; // R7
		end
	end

	assign MEAS_SEQ_SEL = seq_out_reg;

endmodule : mslog_top

// ===== tb/mslog_top_chk.sv
// Concurrent checks on the ports of the meter state and event logger.
`include "mslog_params.svh"

module mslog_top_chk (
	// Clock and reset
	input wire logic MCLK,
	input wire logic RESETN,
	// Wishbone slave
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [31:0] WB_DAT_O,
	input wire logic WB_ACK_O,
	// Metering events and time
	input wire logic INTEGRATION,
	input wire logic FORCED_CALL,
	input wire logic [16:0] TIME_SEC,
	// Meter control
	input wire logic TRANSPORT_STATE,
	input wire logic RADIO_EN,
	input wire logic [3:0] MEAS_SEQ_SEL,
	input wire logic SCHED_LOG
);
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!RESETN);

	// ==========================================================================
	// Bus handshake
	a_ack_single_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("ack longer than one cycle");
	a_ack_after_take: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
		else $error("request not answered in one cycle");
	a_idle_data_zero: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0)
		else $error("read data not zero without ack");

	// ==========================================================================
	// Meter state
	a_transport_sticky: assert property (!TRANSPORT_STATE |=> !TRANSPORT_STATE)
		else $error("transport state entered again");
	a_integ_exits: assert property (TRANSPORT_STATE && INTEGRATION |=> !TRANSPORT_STATE)
		else $error("integration did not end transport");
	a_reduced_seq: assert property (TRANSPORT_STATE |-> MEAS_SEQ_SEL == `MSLOG_REDUCED_SEQ)
		else $error("wrong sequence in transport");
	a_radio_cause: assert property ($rose(RADIO_EN) |-> $past(INTEGRATION) || $past(FORCED_CALL)
		|| $past(WB_WE_I && WB_STB_I) || $past(WB_WE_I && WB_STB_I, 2))
		else $error("radio switched on without cause");
	a_midnight_pulse: assert property (TIME_SEC == 17'h0 && $past(TIME_SEC) != 17'h0 |-> ##[0:1] SCHED_LOG)
		else $error("no scheduled log at midnight");

	c_bus_read: cover property (WB_ACK_O && !WB_WE_I);
	c_leave_transport: cover property ($fell(TRANSPORT_STATE));
	c_sched_log: cover property (SCHED_LOG);
endmodule : mslog_top_chk

bind mslog_top mslog_top_chk mslog_top_chk_inst (.MCLK(MCLK), .RESETN(RESETN), .WB_CYC_I(WB_CYC_I),
	.WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
	.INTEGRATION(INTEGRATION), .FORCED_CALL(FORCED_CALL), .TIME_SEC(TIME_SEC),
	.TRANSPORT_STATE(TRANSPORT_STATE), .RADIO_EN(RADIO_EN), .MEAS_SEQ_SEL(MEAS_SEQ_SEL), .SCHED_LOG(SCHED_LOG));

// ===== tb/test_mslog_top.sv
// Self-checking testbench of the meter state and event logger.
`include "mslog_params.svh"

module test_mslog_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic MCLK = 1'b0, RESETN = 1'b0, WB_CYC_I = 1'b0, WB_STB_I = 1'b0, WB_WE_I = 1'b0, SUMMER_PERIOD = 1'b0;
	logic INTEGRATION = 1'b0, FORCED_CALL = 1'b0, PEAK_STROBE = 1'b0;
	logic [3:0] WB_SEL_I = 4'hf;
	logic [7:0] WB_ADR_I = 8'h0;
	logic [11:0] INFO_CODE = 12'h0;
	logic [15:0] TEMP_OFFSET = 16'h0, TIME_DATE = 16'h0, dt;
	logic [16:0] TIME_SEC = 17'h1, s;
	logic [31:0] WB_DAT_I = 32'h0, HEAT_ENERGY = 32'h0, COOLING_ENERGY = 32'h0, VOLUME_TOTAL = 32'h0;
	logic [31:0] HOUR_COUNTER = 32'h0, WB_DAT_O, rd, cfg;
	logic [31:0] heat_q [1:55];
	logic TRANSPORT_STATE, RADIO_EN, SETUP_ACTIVE, SCHED_LOG, WB_ACK_O;
	logic [3:0] MEAS_SEQ_SEL, m;
	int fail_count, total_checks, k;

	mslog_top mslog_top_inst (.MCLK(MCLK), .RESETN(RESETN), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
		.WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O),
		.WB_ACK_O(WB_ACK_O), .INTEGRATION(INTEGRATION), .FORCED_CALL(FORCED_CALL), .PEAK_STROBE(PEAK_STROBE),
		.INFO_CODE(INFO_CODE), .HEAT_ENERGY(HEAT_ENERGY), .COOLING_ENERGY(COOLING_ENERGY),
		.VOLUME_TOTAL(VOLUME_TOTAL), .HOUR_COUNTER(HOUR_COUNTER), .TEMP_OFFSET(TEMP_OFFSET),
		.TIME_DATE(TIME_DATE), .TIME_SEC(TIME_SEC), .SUMMER_PERIOD(SUMMER_PERIOD),
		.TRANSPORT_STATE(TRANSPORT_STATE), .RADIO_EN(RADIO_EN), .SETUP_ACTIVE(SETUP_ACTIVE),
		.MEAS_SEQ_SEL(MEAS_SEQ_SEL), .SCHED_LOG(SCHED_LOG));

	initial begin
		forever #50 MCLK = ~MCLK;
	end

	// ==========================================================================
	// Bus tasks and expectations
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// The request stays up until ack is sampled, so the wait has no fixed length.
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		WB_CYC_I <= 1'b1;
		WB_STB_I <= 1'b1;
		WB_WE_I <= we;
		WB_ADR_I <= adr;
		WB_DAT_I <= dat;
		@(posedge MCLK);
		while (WB_ACK_O !== 1'b1) begin
			@(posedge MCLK);
		end
		rd = WB_DAT_O;
		WB_CYC_I <= 1'b0;
		WB_STB_I <= 1'b0;
		@(posedge MCLK);
	endtask : wb

	task automatic rdchk(input logic [7:0] adr, input logic [31:0] exp);
		wb(1'b0, adr, 32'h0);
		check(rd, exp);
	endtask : rdchk

	task automatic logchk(input logic lg, input logic [5:0] idx, input logic [2:0] w, input logic [31:0] exp);
		wb(1'b1, `MSLOG_ADR_LOG_SEL, {13'h0, w, 2'h0, idx, 7'h0, lg});
		rdchk(`MSLOG_ADR_LOG_DATA, exp);
	endtask : logchk

	task automatic pulse(input logic integ, input logic forced, input logic peak);
		INTEGRATION <= integ;
		FORCED_CALL <= forced;
		PEAK_STROBE <= peak;
		@(posedge MCLK);
		INTEGRATION <= 1'b0;
		FORCED_CALL <= 1'b0;
		PEAK_STROBE <= 1'b0;
		repeat (2) @(posedge MCLK);
	endtask : pulse

	task automatic set_code(input logic [11:0] c);
		INFO_CODE <= c;
		repeat (2) @(posedge MCLK);
	endtask : set_code

	task automatic do_reset;
		RESETN <= 1'b0;
		INFO_CODE <= 12'h0;
		repeat (3) @(posedge MCLK);
		RESETN <= 1'b1;
		@(posedge MCLK);
	endtask : do_reset

	function automatic logic [31:0] stamp(input logic [16:0] sec, input logic en, input logic incl);
		if (en && incl)
			return {15'h0, 17'((sec + 17'd3600) % 17'd86400)};
		return {14'h0, en, sec};
	endfunction : stamp

	function automatic logic [31:0] status(input logic tr, ra, su, bl, input logic [5:0] cn, fill);
		return {10'h0, fill, 2'h0, cn, 4'h0, bl, su, ra, tr};
	endfunction : status

	task automatic wrap_up;
		$display("checks %0d, mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : wrap_up

	initial begin
		#2000000;
		fail_count++;
		wrap_up();
	end

	// ==========================================================================
	// Test sequence
	initial begin
		k = $urandom(32'hbb29);
		HOUR_COUNTER <= $urandom;
		TEMP_OFFSET <= 16'($urandom);
		do_reset();
		rdchk(`MSLOG_ADR_STATUS, status(1, 0, 0, 0, 0, 0));
		rdchk(`MSLOG_ADR_CTRL, 32'h4);
		rdchk(`MSLOG_ADR_INFO_MASK, 32'hfff);
		rdchk(8'h3c, 32'h0);
		$display("test reset done");
		repeat (4) set_code(12'($urandom));
		rdchk(`MSLOG_ADR_EVENT_COUNT, 32'h0);
		check(MEAS_SEQ_SEL, 4'hf);
		wb(1'b1, `MSLOG_ADR_CTRL, 32'h0);
		wb(1'b1, `MSLOG_ADR_CMD, 32'h1);
		check(SETUP_ACTIVE, 1'b0);
		wb(1'b1, `MSLOG_ADR_CTRL, 32'h4);
		wb(1'b1, `MSLOG_ADR_CMD, 32'h1);
		rdchk(`MSLOG_ADR_STATUS, status(1, 0, 1, 0, 0, 0));
		wb(1'b1, `MSLOG_ADR_CMD, 32'h8);
		check(RADIO_EN, 1'b1);
		check(TRANSPORT_STATE, 1'b1);
		wb(1'b1, `MSLOG_ADR_CMD, 32'h2);
		rdchk(`MSLOG_ADR_STATUS, status(1, 1, 0, 0, 1, 0));
		pulse(1'b1, 1'b0, 1'b0);
		check(TRANSPORT_STATE, 1'b0);
		check(MEAS_SEQ_SEL, 4'h0);
		$display("test transport done");
		do_reset();
		wb(1'b1, `MSLOG_ADR_CMD, 32'h1);
		wb(1'b1, `MSLOG_ADR_CMD, 32'h4);
		wb(1'b1, `MSLOG_ADR_CMD, 32'h1);
		rdchk(`MSLOG_ADR_STATUS, status(0, 0, 0, 1, 1, 0));
		check(SETUP_ACTIVE, 1'b0);
		m = 4'($urandom % 15);
		wb(1'b1, `MSLOG_ADR_MEAS_SEQ, {28'h0, m});
		check(MEAS_SEQ_SEL, m);
		pulse(1'b0, 1'b1, 1'b0);
		wb(1'b1, `MSLOG_ADR_CTRL, 32'hc);
		check(RADIO_EN, 1'b0);
		pulse(1'b1, 1'b1, 1'b0);
		check(RADIO_EN, 1'b0);
		wb(1'b1, `MSLOG_ADR_CTRL, 32'h4);
		pulse(1'b1, 1'b0, 1'b0);
		check(RADIO_EN, 1'b1);
		$display("test finish and radio done");
		for (k = 1; k <= 55; k++) begin
			heat_q[k] = $urandom;
			HEAT_ENERGY <= heat_q[k];
			set_code(12'(k));
		end
		rdchk(`MSLOG_ADR_STATUS, status(0, 1, 0, 1, 1, 50));
		rdchk(`MSLOG_ADR_EVENT_COUNT, 32'd55);
		logchk(0, 0, 2, 32'd55);
		logchk(0, 0, 3, heat_q[55]);
		logchk(0, 49, 2, 32'd6);
		logchk(0, 49, 3, heat_q[6]);
		logchk(0, 50, 2, 32'h0);
		set_code(12'h00f);
		set_code(12'h000);
		wb(1'b1, `MSLOG_ADR_INFO_MASK, 32'h0f0);
		set_code(12'h00f);
		set_code(12'h0ff);
		set_code(12'h0f3);
		rdchk(`MSLOG_ADR_EVENT_COUNT, 32'd58);
		logchk(0, 0, 2, 32'h0f0);
		logchk(0, 2, 2, 32'h00f);
		$display("test info log done");
		s = 17'($urandom % 86399) + 17'h1;
		dt = 16'($urandom);
		TIME_SEC <= s;
		TIME_DATE <= dt;
		SUMMER_PERIOD <= 1'b1;
		wb(1'b1, `MSLOG_ADR_CTRL, 32'h5);
		set_code(12'h000);
		for (k = 0; k < 4; k++) begin
			wb(1'b1, `MSLOG_ADR_CTRL, 32'h4 | 32'(k));
			logchk(0, 0, 0, stamp(s, k[0], k[1]));
		end
		logchk(0, 0, 1, {16'h0, dt});
		pulse(1'b0, 1'b0, 1'b1);
		rdchk(`MSLOG_ADR_PEAK_DATE, {16'h0, dt});
		rdchk(`MSLOG_ADR_PEAK_TIME, stamp(s, 1'b1, 1'b1));
		TIME_SEC <= 17'h1517f;
		@(posedge MCLK);
		TIME_SEC <= 17'h0;
		k = 0;
		repeat (3) begin
			@(posedge MCLK);
			if (SCHED_LOG === 1'b1)
				k++;
		end
		check(k, 1);
		TIME_SEC <= 17'h1;
		$display("test summer time done");
		do_reset();
		cfg = $urandom;
		wb(1'b1, `MSLOG_ADR_CONFIG_NUM, cfg);
		repeat (26) begin
			wb(1'b1, `MSLOG_ADR_CMD, 32'h1);
			wb(1'b1, `MSLOG_ADR_CMD, 32'h2);
		end
		rdchk(`MSLOG_ADR_STATUS, status(1, 0, 0, 0, 25, 0));
		logchk(1, 0, 2, cfg);
		logchk(1, 0, 6, HOUR_COUNTER);
		logchk(1, 0, 7, {16'h0, TEMP_OFFSET});
		do_reset();
		rdchk(`MSLOG_ADR_STATUS, status(1, 0, 0, 0, 0, 0));
		logchk(1, 0, 2, 32'h0);
		$display("test config log done");
		wrap_up();
	end
endmodule : test_mslog_top
